// ### rtl/qrt_cnt_if.sv
// Link between a counter owner and one reload counter
`timescale 1ns/1ps
interface qrt_cnt_if #(parameter int W = 8);
    logic         ld_latch;  // Load reload latch
    logic         ld_count;  // Load running counter
    logic [W-1:0] ld_val;    // Value to load
    logic         tick;      // Count pulse
    logic [W-1:0] count;     // Current count
    logic [W-1:0] latch;     // Reload value
    logic         uf;        // Underflow pulse
    modport ctr (input ld_latch, ld_count, ld_val, tick, output count, latch, uf);
    modport drv (output ld_latch, ld_count, ld_val, tick, input count, latch, uf);
endinterface : qrt_cnt_if

// ### rtl/qrt_pkg.sv
// Types shared by the four-timer reload unit
package qrt_pkg;
    // Operating modes of the mode-capable timer
    typedef enum logic [1:0] {QRT_TIMER, QRT_PULSE, QRT_EVENT, QRT_WIDTH} qrt_mode_t;
endpackage : qrt_pkg

// ### rtl/qrt_regs.svh
// Constants of the four-timer reload unit
//
// Function
// - Each divider divides by latch plus one
// - Count down, underflow after zero, reload, request
// - Divider source: main oscillator, ring on 10
// - Fixed timer counts fixed prescaler, divider source/16
// - 8-bit writes load latch and counter; read count
// - Fixed pair always timer mode, never stops
// - 8-bit timer steps on prescaler underflow
// - Mode prescaler uses selected count source
// - Mode timer: timer, pulse, event, width modes
// - Pulse mode toggles counter pin on underflow
// - Pulse output starts high on polarity 0
// - Output enable drives inverted pulse pin
// - Event mode counts chosen counter pin edges
// - Width mode counts only during chosen level
// - Count-stop bit halts mode pair always
// - Pin request: fall on polarity 0, else rise
// - Wide timers pick divided clock or alternate
// - Wide timers underflow after 0000, reload, request
// - Write control: latch only or both
`ifndef QRT_REGS_SVH
`define QRT_REGS_SVH
`define QRT_DIV_RING    2'b10
`define QRT_DIV2_B      0
`define QRT_DIV16_B     3
`define QRT_DIV32_B     4
`define QRT_DIV64_B     5
`define QRT_DIV128_B    6
`define QRT_DIV256_B    7
`define QRT_MSRC_DIV2   2'h0
`define QRT_MSRC_DIV16  2'h1
`define QRT_MSRC_DIV256 2'h2
`define QRT_WSRC_ALT    3'h6
`define QRT_TOP_RST     11'h002
`endif

// ### rtl/qrt_reload_ctr.sv
// Down counter with reload latch
`timescale 1ns/1ps
module qrt_reload_ctr
    import qrt_pkg::*;
#(parameter int W = 8) (
    input wire logic sys_clk,
    input wire logic nrst,
    qrt_cnt_if.ctr   c
);
    // ==========================================
    // State
    typedef struct packed {
        logic [W-1:0] latch;  // Reload value
        logic [W-1:0] count;  // Running count
    } qrt_rc_t;
    qrt_rc_t s_r;    // Registered state
    qrt_rc_t s_nxt;  // Next state

    // Loads win over counting
    always_comb begin
        s_nxt = s_r;
        if (c.ld_latch) begin
            s_nxt.latch = c.ld_val;
        end
        if (c.ld_count) begin
            s_nxt.count = c.ld_val;
        end else if (c.tick) begin
            // Reload after zero, else step down
            s_nxt.count = (s_r.count == '0) ? s_r.latch : s_r.count - 1'b1;
        end
    end

    // Register the state
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign c.count = s_r.count;
    assign c.latch = s_r.latch;
    assign c.uf    = c.tick && (s_r.count == '0) && !c.ld_count;

    // ==========================================
    // Checks
    a_uf_reload: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        c.uf |=> s_r.count == $past(s_r.latch))
        else $error("counter did not reload on underflow");
    a_count_step: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (c.tick && s_r.count != '0 && !c.ld_count) |=> s_r.count == $past(s_r.count) - 1'b1)
        else $error("counter did not step down by one");
endmodule : qrt_reload_ctr

// ### rtl/qrt_top.sv
// Four reload timers: fixed pair, mode pair, two wide timers
`timescale 1ns/1ps
`include "qrt_regs.svh"
module qrt_top
    import qrt_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic [1:0] clk_div_sel,
    input  wire logic       ring_osc_tick,
    input  wire logic [7:0] wr_data,
    input  wire logic       fixed_prescaler_wr,
    input  wire logic       fixed_timer_wr,
    input  wire logic       mode_prescaler_wr,
    input  wire logic       mode_timer_wr,
    output logic      [7:0] fixed_prescaler_cnt,
    output logic      [7:0] fixed_timer_cnt,
    output logic      [7:0] mode_prescaler_cnt,
    output logic      [7:0] mode_timer_cnt,
    input  wire logic [1:0] mode_sel,
    input  wire logic [1:0] mode_src_sel,
    input  wire logic       edge_pol,
    input  wire logic       count_stop,
    input  wire logic       tx_out_en,
    input  wire logic       counter_pin_in,
    output logic            counter_pin_o,
    output logic            counter_pin_oe_n,
    output logic            inverted_timer_output_pin_o,
    output logic            inverted_timer_output_pin_oe_n,
    input  wire logic [2:0] wide_a_src_sel,
    input  wire logic [2:0] wide_b_src_sel,
    input  wire logic       wide_a_latch_only,
    input  wire logic       wide_b_latch_only,
    input  wire logic       wide_timer_a_low_wr,
    input  wire logic       wide_timer_a_high_wr,
    input  wire logic       wide_timer_a_high_rd,
    input  wire logic       wide_timer_b_low_wr,
    input  wire logic       wide_timer_b_high_wr,
    input  wire logic       wide_timer_b_high_rd,
    output logic      [7:0] wide_timer_a_high,
    output logic      [7:0] wide_timer_a_low,
    output logic      [7:0] wide_timer_b_high,
    output logic      [7:0] wide_timer_b_low,
    output logic            fixed_timer_irq,
    output logic            mode_timer_irq,
    output logic            counter_pin_irq,
    output logic            wide_a_irq,
    output logic            wide_b_irq
);
    // ==========================================
    // State
    typedef struct packed {
        logic [7:0] div;       // Frequency divider count
        logic       pin_prev;  // Counter pin one cycle ago
        logic       pout;      // Pulse output level
        logic       tx;        // Inverted pulse output level
    } qrt_top_t;
    qrt_top_t s_r;    // Registered state
    qrt_top_t s_nxt;  // Next state

    qrt_mode_t  mode;       // Decoded operating mode
    logic       src_tick;   // Divider input pulse
    logic [5:0] divs;       // Divided enables, 1/2 up to 1/256
    logic       pin_rise;   // Counter pin rising edge
    logic       pin_fall;   // Counter pin falling edge
    logic       ev_edge;    // Counted edge in event mode
    logic       mode_base;  // Selected source of mode prescaler
    logic       mode_pt;    // Mode prescaler count pulse
    logic       run;        // Mode pair not stopped
    logic       wa_tick;    // Wide timer A count pulse
    logic       wb_tick;    // Wide timer B count pulse
    logic       wa_uf;      // Wide timer A underflow

    qrt_cnt_if #(.W(8)) fp_if ();  // Fixed prescaler link
    qrt_cnt_if #(.W(8)) ft_if ();  // Fixed timer link
    qrt_cnt_if #(.W(8)) mp_if ();  // Mode prescaler link
    qrt_cnt_if #(.W(8)) mt_if ();  // Mode timer link

    // ==========================================
    // Wide timer source pick
    function automatic logic pick_src(input logic [2:0] sel, input logic [5:0] d,
                                      input logic alt);
        // Codes past the divided clocks choose the alternate
        if (sel < `QRT_WSRC_ALT) begin
            pick_src = d[sel];
        end else begin
            pick_src = alt;
        end
    endfunction : pick_src

    // ==========================================
    // Frequency divider
    // Ring code takes ring pulses, every other code the main clock
    assign src_tick = (clk_div_sel == `QRT_DIV_RING) ? ring_osc_tick : 1'b1;

    // Each enable fires when the low divider bits are all ones
    assign divs[0] = src_tick && (&s_r.div[`QRT_DIV2_B:0]);
    assign divs[1] = src_tick && (&s_r.div[`QRT_DIV16_B:0]);
    assign divs[2] = src_tick && (&s_r.div[`QRT_DIV32_B:0]);
    assign divs[3] = src_tick && (&s_r.div[`QRT_DIV64_B:0]);
    assign divs[4] = src_tick && (&s_r.div[`QRT_DIV128_B:0]);
    assign divs[5] = src_tick && (&s_r.div[`QRT_DIV256_B:0]);

    // ==========================================
    // Fixed pair: always timer mode, no stop input
    assign fp_if.ld_latch = fixed_prescaler_wr;
    assign fp_if.ld_count = fixed_prescaler_wr;
    assign fp_if.ld_val   = wr_data;
    assign fp_if.tick     = divs[1];
    assign ft_if.ld_latch = fixed_timer_wr;
    assign ft_if.ld_count = fixed_timer_wr;
    assign ft_if.ld_val   = wr_data;
    assign ft_if.tick     = fp_if.uf;

    // ==========================================
    // Mode pair count pulse
    assign mode     = qrt_mode_t'(mode_sel);
    assign pin_rise = counter_pin_in && !s_r.pin_prev;
    assign pin_fall = !counter_pin_in && s_r.pin_prev;
    assign ev_edge  = edge_pol ? pin_fall : pin_rise;
    assign run      = !count_stop;

    // Source for the mode prescaler
    always_comb begin
        unique case (mode_src_sel)
            `QRT_MSRC_DIV2:   mode_base = divs[0];
            `QRT_MSRC_DIV16:  mode_base = divs[1];
            `QRT_MSRC_DIV256: mode_base = divs[5];
            default:          mode_base = ring_osc_tick;
        endcase
    end

    // Mode decides what feeds the prescaler
    always_comb begin
        unique case (mode)
            QRT_TIMER: mode_pt = mode_base;
            QRT_PULSE: mode_pt = mode_base;
            // Edges on the pin replace the source
            QRT_EVENT: mode_pt = ev_edge;
            // Source passes only during the active level
            QRT_WIDTH: mode_pt = mode_base && (counter_pin_in != edge_pol);
        endcase
    end

    assign mp_if.ld_latch = mode_prescaler_wr;
    assign mp_if.ld_count = mode_prescaler_wr;
    assign mp_if.ld_val   = wr_data;
    assign mp_if.tick     = run && mode_pt;
    assign mt_if.ld_latch = mode_timer_wr;
    assign mt_if.ld_count = mode_timer_wr;
    assign mt_if.ld_val   = wr_data;
    assign mt_if.tick     = run && mp_if.uf;

    // ==========================================
    // Next state
    always_comb begin
        s_nxt = s_r;
        // Divider steps on each source pulse
        if (src_tick) begin
            s_nxt.div = s_r.div + 1'b1;
        end
        s_nxt.pin_prev = counter_pin_in;
        if (mode != QRT_PULSE) begin
            // Preset start level outside pulse mode
            s_nxt.pout = !edge_pol;
        end else if (mt_if.uf) begin
            // Flip on every underflow
            s_nxt.pout = !s_r.pout;
        end
        s_nxt.tx = !s_nxt.pout;
    end

    // Register the state
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s_r <= `QRT_TOP_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================
    // Wide timers
    assign wa_tick = pick_src(wide_a_src_sel, divs, ring_osc_tick);
    assign wb_tick = pick_src(wide_b_src_sel, divs, wa_uf);

    qrt_wide_timer u_wide_a (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .src_tick   (wa_tick),
        .latch_only (wide_a_latch_only),
        .low_wr     (wide_timer_a_low_wr),
        .high_wr    (wide_timer_a_high_wr),
        .high_rd    (wide_timer_a_high_rd),
        .wr_data    (wr_data),
        .high_q     (wide_timer_a_high),
        .low_q      (wide_timer_a_low),
        .uf         (wa_uf)
    );

    qrt_wide_timer u_wide_b (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .src_tick   (wb_tick),
        .latch_only (wide_b_latch_only),
        .low_wr     (wide_timer_b_low_wr),
        .high_wr    (wide_timer_b_high_wr),
        .high_rd    (wide_timer_b_high_rd),
        .wr_data    (wr_data),
        .high_q     (wide_timer_b_high),
        .low_q      (wide_timer_b_low),
        .uf         (wide_b_irq)
    );

    // ==========================================
    // Eight-bit counters
    qrt_reload_ctr #(.W(8)) u_fixed_pre (.sys_clk(sys_clk), .nrst(nrst), .c(fp_if));
    qrt_reload_ctr #(.W(8)) u_fixed_tmr (.sys_clk(sys_clk), .nrst(nrst), .c(ft_if));
    qrt_reload_ctr #(.W(8)) u_mode_pre  (.sys_clk(sys_clk), .nrst(nrst), .c(mp_if));
    qrt_reload_ctr #(.W(8)) u_mode_tmr  (.sys_clk(sys_clk), .nrst(nrst), .c(mt_if));

    // ==========================================
    // Outputs
    assign fixed_prescaler_cnt = fp_if.count;
    assign fixed_timer_cnt     = ft_if.count;
    assign mode_prescaler_cnt  = mp_if.count;
    assign mode_timer_cnt      = mt_if.count;
    // Pin driven only in pulse mode
    assign counter_pin_o       = s_r.pout;
    assign counter_pin_oe_n    = (mode != QRT_PULSE);
    assign inverted_timer_output_pin_o    = s_r.tx;
    assign inverted_timer_output_pin_oe_n = !tx_out_en;
    // Request pulses
    assign fixed_timer_irq = ft_if.uf;
    assign mode_timer_irq  = mt_if.uf;
    assign counter_pin_irq = edge_pol ? pin_rise : pin_fall;
    assign wide_a_irq      = wa_uf;

    // ==========================================
    // Checks
    sequence s_pin_fall;
        counter_pin_in ##1 !counter_pin_in;
    endsequence
    sequence s_pin_rise;
        !counter_pin_in ##1 counter_pin_in;
    endsequence

    a_pin_irq_fall: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (s_pin_fall ##0 !edge_pol) |-> counter_pin_irq)
        else $error("falling edge request missing");
    a_pin_irq_rise: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (s_pin_rise ##0 edge_pol) |-> counter_pin_irq)
        else $error("rising edge request missing");
    a_pulse_toggle: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (mode == QRT_PULSE && mt_if.uf) |=> counter_pin_o == !$past(counter_pin_o))
        else $error("pulse output did not toggle");
    a_pulse_start: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (mode != QRT_PULSE) |=> counter_pin_o == !$past(edge_pol))
        else $error("pulse start level wrong");
    a_inv_output: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        tx_out_en |-> (!inverted_timer_output_pin_oe_n
                       && inverted_timer_output_pin_o == !counter_pin_o))
        else $error("inverted output pin wrong");
    a_stop_hold: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (count_stop && !mode_prescaler_wr && !mode_timer_wr)[*2]
        |-> mode_prescaler_cnt == $past(mode_prescaler_cnt)
            && mode_timer_cnt == $past(mode_timer_cnt))
        else $error("stopped mode pair still counting");
    a_ring_hold: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (clk_div_sel == `QRT_DIV_RING && !ring_osc_tick && !fixed_prescaler_wr)
        |=> fixed_prescaler_cnt == $past(fixed_prescaler_cnt))
        else $error("fixed prescaler moved without ring pulse");
    a_width_gate: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (mode == QRT_WIDTH && counter_pin_in == edge_pol) |-> !mp_if.tick)
        else $error("width mode counted during idle level");
endmodule : qrt_top

// ### rtl/qrt_wide_timer.sv
// Sixteen-bit timer with byte access buffers
`timescale 1ns/1ps
module qrt_wide_timer
    import qrt_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       src_tick,
    input  wire logic       latch_only,
    input  wire logic       low_wr,
    input  wire logic       high_wr,
    input  wire logic       high_rd,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] high_q,
    output logic      [7:0] low_q,
    output logic            uf
);
    // ==========================================
    // State
    typedef struct packed {
        logic [7:0] low_buf;  // Written low byte
        logic [7:0] low_frz;  // Low byte frozen by high read
    } qrt_wt_t;
    qrt_wt_t s_r;    // Registered state
    qrt_wt_t s_nxt;  // Next state
    qrt_cnt_if #(.W(16)) cif ();  // Counter link

    // Byte buffering
    always_comb begin
        s_nxt = s_r;
        if (low_wr) begin
            s_nxt.low_buf = wr_data;
        end
        if (high_rd) begin
            s_nxt.low_frz = cif.count[7:0];
        end
    end

    // Register the state
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // High write commits both bytes
    assign cif.ld_latch = high_wr;
    assign cif.ld_count = high_wr && !latch_only;
    assign cif.ld_val   = {wr_data, s_r.low_buf};
    assign cif.tick     = src_tick;
    assign high_q       = cif.count[15:8];
    assign low_q        = s_r.low_frz;
    assign uf           = cif.uf;

    qrt_reload_ctr #(.W(16)) u_ctr (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .c       (cif)
    );

    // ==========================================
    // Checks
    a_high_commit: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (high_wr && !latch_only) |=> cif.count == {$past(wr_data), $past(s_r.low_buf)})
        else $error("high write did not commit both bytes");
    a_latch_only: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (high_wr && latch_only && !src_tick) |=> cif.count == $past(cif.count))
        else $error("latch-only write disturbed the counter");
endmodule : qrt_wide_timer

// ### verif/qrt_pin_src.sv
// Pulse source that stands on the counter pin outside the device
`timescale 1ns/1ps
module qrt_pin_src (
    input  wire logic       sys_clk,
    input  wire logic       start,   // Begin a burst
    input  wire logic [7:0] pulses,  // Pulses per burst
    input  wire logic [7:0] hi_len,  // Cycles high
    input  wire logic [7:0] lo_len,  // Cycles low
    output logic            pin,     // Level driven on the pin
    output logic            busy     // Burst in progress
);
    // ====================
    // Burst generator; rests low between bursts
    initial begin
        pin  = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge sys_clk iff start);
            busy <= 1'b1;
            repeat (pulses) begin
                #1 pin = 1'b1;
                repeat (hi_len) @(posedge sys_clk);
                #1 pin = 1'b0;
                repeat (lo_len) @(posedge sys_clk);
            end
            busy <= 1'b0;
        end
    end
endmodule : qrt_pin_src

// ### verif/tb.sv
// Self-checking bench of the four-timer reload unit
`timescale 1ns/1ps
module tb;
    import qrt_pkg::*;
    // ====================
    // Signals
    logic       sys_clk, nrst, ring_osc_tick, edge_pol, count_stop, tx_out_en;
    logic       wide_a_latch_only, wide_b_latch_only, src_start, src_pin, src_busy;
    logic       counter_pin_o, counter_pin_oe_n;
    logic       inverted_timer_output_pin_o, inverted_timer_output_pin_oe_n;
    logic [1:0] clk_div_sel, mode_sel, mode_src_sel;
    logic [2:0] wide_a_src_sel, wide_b_src_sel;
    logic [3:0] sw;                       // Byte write strobes
    logic [5:0] ww;                       // Wide low, high, read strobes
    logic [4:0] irq_vec;                  // All request pulses
    logic [7:0] wr_data, src_pulses, src_hi, src_lo;
    logic [7:0] fixed_prescaler_cnt, fixed_timer_cnt, mode_prescaler_cnt, mode_timer_cnt;
    logic [7:0] wide_timer_a_high, wide_timer_a_low, wide_timer_b_high, wide_timer_b_low;
    logic       fixed_timer_irq, mode_timer_irq, counter_pin_irq, wide_a_irq, wide_b_irq;
    wire        counter_pin_in = counter_pin_oe_n ? src_pin : counter_pin_o; // Wire level
    int errors, tests_run, cyc_n, ring_cnt, seed, last, mon_sel, mon_e, n, m, h1, h2;
    int exp_q[$];                         // Expected request intervals
    int hits[5];                          // Request pulse counts
    int dv[4] = '{2, 16, 256, 3};         // Mode prescaler source periods
    assign irq_vec = {wide_b_irq, wide_a_irq, counter_pin_irq, mode_timer_irq, fixed_timer_irq};

    qrt_top uut (.sys_clk, .nrst, .clk_div_sel, .ring_osc_tick, .wr_data,
        .fixed_prescaler_wr(sw[0]), .fixed_timer_wr(sw[1]), .mode_prescaler_wr(sw[2]),
        .mode_timer_wr(sw[3]), .fixed_prescaler_cnt, .fixed_timer_cnt, .mode_prescaler_cnt,
        .mode_timer_cnt, .mode_sel, .mode_src_sel, .edge_pol, .count_stop, .tx_out_en,
        .counter_pin_in, .counter_pin_o, .counter_pin_oe_n, .inverted_timer_output_pin_o,
        .inverted_timer_output_pin_oe_n, .wide_a_src_sel, .wide_b_src_sel, .wide_a_latch_only,
        .wide_b_latch_only, .wide_timer_a_low_wr(ww[0]), .wide_timer_a_high_wr(ww[1]),
        .wide_timer_a_high_rd(ww[2]), .wide_timer_b_low_wr(ww[3]), .wide_timer_b_high_wr(ww[4]),
        .wide_timer_b_high_rd(ww[5]), .wide_timer_a_high, .wide_timer_a_low, .wide_timer_b_high,
        .wide_timer_b_low, .fixed_timer_irq, .mode_timer_irq, .counter_pin_irq, .wide_a_irq,
        .wide_b_irq);
    qrt_pin_src src (.sys_clk, .start(src_start), .pulses(src_pulses), .hi_len(src_hi),
        .lo_len(src_lo), .pin(src_pin), .busy(src_busy));

    // ====================
    // Clock, ring pulses every third cycle, hang limit
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc_n++;
        ring_cnt = (ring_cnt == 2) ? 0 : ring_cnt + 1;
        #1 ring_osc_tick = (ring_cnt == 0);
        if (cyc_n == 60000) begin
            errors++;
            print_verdict();
        end
    end
    // Monitor: takes the oldest expected interval at each watched request
    always @(negedge sys_clk) begin
        for (int i = 0; i < 5; i++) if (irq_vec[i] === 1'b1) hits[i]++;
        if (irq_vec[mon_sel] === 1'b1) begin
            if (exp_q.size() > 0) begin
                mon_e = exp_q.pop_front();
                if (mon_e != 0) chk(cyc_n - last, mon_e);
            end
            last = cyc_n;
        end
    end

    // ====================
    // Tasks
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr8(input int i, input logic [7:0] d);   // One strobe, one byte
        sw[i] = 1'b1;
        wr_data = d;
        cyc(1);
        sw[i] = 1'b0;
    endtask : wr8
    task automatic wst(input int i, input logic [7:0] d);   // Wide strobe
        ww[i] = 1'b1;
        wr_data = d;
        cyc(1);
        ww[i] = 1'b0;
    endtask : wst
    task automatic periods(input int s, input int p);       // Sync pulse, then two periods
        mon_sel = s;
        exp_q = {0, p, p};
        for (int i = 0; i < 10000 && exp_q.size() > 0; i++) cyc(1);
        chk(exp_q.size(), 0);
        exp_q.delete();
    endtask : periods
    task automatic burst(input int k, input int h, input int l);
        src_pulses = k[7:0];
        src_hi = h[7:0];
        src_lo = l[7:0];
        src_start = 1'b1;
        cyc(1);
        src_start = 1'b0;
        for (int i = 0; i < 2000 && src_busy; i++) cyc(1);
        cyc(4);
    endtask : burst
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // ====================
    // Main sequence
    initial begin
        seed = 32'h93be6552;
        {nrst, edge_pol, count_stop, tx_out_en, src_start} = '0;
        {wide_a_latch_only, wide_b_latch_only, clk_div_sel, mode_src_sel} = '0;
        {wide_a_src_sel, wide_b_src_sel, sw, ww, wr_data, src_pulses} = '0;
        {src_hi, src_lo} = {8'h01, 8'h01};
        mode_sel = QRT_TIMER;
        cyc(2);
        nrst = 1'b1;
        cyc(1);
        chk({fixed_prescaler_cnt, fixed_timer_cnt, mode_prescaler_cnt, mode_timer_cnt}, 0);
        chk({counter_pin_o, inverted_timer_output_pin_o}, 2'h2);
        done("reset");
        for (int c = 0; c < 4; c++) begin                  // Every divider source code
            n = $random(seed) & 3;
            m = $random(seed) & 3;
            clk_div_sel = c[1:0];
            wr8(0, n[7:0]);
            chk(fixed_prescaler_cnt, n);
            wr8(1, m[7:0]);
            chk(fixed_timer_cnt, m);
            periods(0, ((c == 2) ? 3 : 1) * 16 * (n + 1) * (m + 1));
        end
        done("fixed");
        clk_div_sel = 2'h0;
        wr8(0, 8'h00);
        wr8(1, 8'h00);
        for (int s = 0; s < 4; s++) begin                  // Every mode prescaler source
            mode_src_sel = s[1:0];
            wr8(2, 8'h01);
            wr8(3, 8'h01);
            periods(1, dv[s] * 2 * 2);
        end
        count_stop = 1'b1;
        cyc(2);
        {h1, h2, n} = {hits[1], hits[0], 32'(mode_prescaler_cnt)};
        cyc(60);
        chk(hits[1] - h1, 0);
        chk(mode_prescaler_cnt, n);
        chk(hits[0] - h2 > 2, 1);
        count_stop = 1'b0;
        done("mode timer");
        mode_src_sel = 2'h0;
        for (int p = 0; p < 2; p++) begin                  // Both start levels
            mode_sel = QRT_TIMER;
            edge_pol = p[0];
            cyc(3);
            {mode_sel, tx_out_en} = {QRT_PULSE, 1'b1};     // Pins set to output first
            wr8(2, 8'h00);
            wr8(3, 8'h02);
            chk({counter_pin_o, counter_pin_oe_n}, {!p[0], 1'b0});
            periods(1, 6);
            cyc(2);
            chk(counter_pin_o, p[0]);
            chk({inverted_timer_output_pin_o, inverted_timer_output_pin_oe_n}, {!p[0], 1'b0});
        end
        done("pulse");
        {mode_sel, tx_out_en} = {QRT_EVENT, 1'b0};
        for (int p = 0; p < 2; p++) begin                  // Both edge choices
            edge_pol = p[0];
            cyc(4);                                        // Let a stray request pass
            wr8(2, 8'h00);
            wr8(3, 8'h03);
            {h1, h2} = {hits[1], hits[2]};
            burst(4, 3, 3);
            chk(hits[1] - h1, 1);
            chk(hits[2] - h2, 4);
            chk(mode_timer_cnt, 8'h03);
        end
        done("event");
        {mode_sel, edge_pol} = {QRT_WIDTH, 1'b0};
        cyc(3);
        wr8(2, 8'hff);
        cyc(20);
        chk(mode_prescaler_cnt, 8'hff);
        burst(1, 40, 2);
        chk((8'hff - mode_prescaler_cnt) inside {[19:21]}, 1);
        done("width");
        wst(0, 8'h03);                                     // Low byte first
        wst(1, 8'h01);
        chk(wide_timer_a_high, 8'h01);
        periods(3, 2 * 16'h0104);
        wide_b_src_sel = 3'h6;
        wst(3, 8'h01);
        wst(4, 8'h00);
        periods(4, 2 * 16'h0104 * 2);
        wide_a_latch_only = 1'b1;
        wst(0, 8'h09);
        wst(1, 8'h05);
        chk(wide_timer_a_high == 8'h05, 0);
        periods(3, 2 * 16'h050a);
        {wide_a_latch_only, wide_a_src_sel} = {1'b0, 3'h5};
        wst(0, 8'h45);
        wst(1, 8'h03);
        wst(2, 8'h00);                                     // High byte read first
        cyc(2);
        chk({wide_timer_a_high, wide_timer_a_low}, 16'h0345);
        wst(3, 8'h22);                                     // Wide B commit, then read
        wst(4, 8'h11);
        wst(5, 8'h00);
        cyc(2);
        chk({wide_timer_b_high, wide_timer_b_low}, 16'h1122);
        wide_a_src_sel = 3'h6;                             // Ring alternate for A
        wst(0, 8'h01);
        wst(1, 8'h00);
        periods(3, 3 * 2);
        done("wide");
        print_verdict();
    end
endmodule : tb
